/* File: mtc_bus_master.sv */
/*
 mtc_bus_master: behavioural register bus master for the timer.
 Assumes one access per request pulse, read data one cycle later.
*/
`timescale 1ns/1ps
module mtc_bus_master (
	// clock
	input wire logic clock_in,
	// register port
	output mtc_pkg::mtc_bus_req_t bus_req_out,
	input wire logic [15:0] bus_rdata_in
);
	// bus idles with no strobe
	initial bus_req_out = '0;
	// one-cycle write pulse, released data shows its inverse
	task automatic bus_write(input logic [7:0] a, input logic [1:0] be, input logic [15:0] d);
		@(posedge clock_in);
		bus_req_out <= '{wr: 1'b1, rd: 1'b0, be: be, addr: a, wdata: d};
		@(posedge clock_in);
		bus_req_out <= '{wr: 1'b0, rd: 1'b0, be: 2'h0, addr: ~a, wdata: ~d};
	endtask
	// one-cycle read pulse, data taken after the answering edge
	task automatic bus_read(input logic [7:0] a, output logic [15:0] d);
		@(posedge clock_in);
		bus_req_out <= '{wr: 1'b0, rd: 1'b1, be: 2'h3, addr: a, wdata: 16'h0000};
		@(posedge clock_in);
		bus_req_out.rd <= 1'b0;
		#1 d = bus_rdata_in;
	endtask
endmodule // mtc_bus_master

/* File: mtc_pin_sync.sv */
/*
 mtc_pin_sync: two-stage synchroniser and edge detector for pins.
 Assumes pins are asynchronous to clock_in.
*/
`timescale 1ns/1ps
module mtc_pin_sync (
	// clock and reset
	input wire logic clock_in,
	input wire logic reset_n_in,
	// raw pins
	input wire logic [mtc_pkg::PIN_W-1:0] raw_in,
	// conditioned levels and edges
	output mtc_pkg::mtc_edges_t edges_out
);
	typedef struct packed {
		logic [mtc_pkg::PIN_W-1:0] s1;
		logic [mtc_pkg::PIN_W-1:0] s2;
		logic [mtc_pkg::PIN_W-1:0] s3;
	} mtc_sync_state_t;
	mtc_sync_state_t st, next_st;

	// ============================================================
	// shift chain, s1 read by s2 only
	always_comb begin
		next_st.s1 = raw_in;
		next_st.s2 = st.s1; // RL27
		next_st.s3 = st.s2;
	end

	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// edges from the settled stages
	assign edges_out = '{level: st.s2, rise: st.s2 & ~st.s3, fall: ~st.s2 & st.s3};

	a_sync_two_stage: assert property (@(posedge clock_in) disable iff (!reset_n_in) // RL27
		$past(reset_n_in, 3) |-> edges_out.level == $past(raw_in, 2))
		else $error("pin level not delayed by two stages");
endmodule // mtc_pin_sync

/* File: mtc_pkg.sv */
/*
 mtc_pkg: register map, field positions, reset values and carriers
 for the three-channel capture/compare timer.
 Assumes a 16-bit bus master; the upper byte lane is the even address.
*/
// ============================================================
// Overview of operation
// (RL1) Reset and standby clear sync select to zero; channels start independent.
// (RL2) Sync select bits 7 to 3 read zero; bits 2 to 0 serve channels 2 to 0.
// (RL3) A counter write on a synced channel loads every synced channel that cycle.
// (RL4) Software sets at least two sync bits for useful synchronous operation.
// (RL5) Synchronous clear needs the sync bit and the sync clear source selected.
// (RL6) Counters and general registers take only whole 16-bit accesses.
// (RL7) Other registers are 8-bit, reachable by byte or paired 16-bit access.
// (RL8) A counter counts only while its run bit is one, on its selected clock.
// (RL9) Counters run free after reset, wrap all ones to zero, set overflow flag.
// (RL10) Overflow flag with its enable raises the channel interrupt request.
// (RL11) Match on the selected clear register sets its flag and zeroes the counter.
// (RL12) Match or capture flag with its enable raises the channel interrupt request.
// (RL13) Compare match drives the pin low, high or toggled per its pin control.
// (RL14) Before the first match the pin holds the programmed initial level.
// (RL15) A fixed match level equal to the current pin level changes nothing.
// (RL16) Capture copies the counter on rising, falling or both pin edges.
// (RL17) Channels 0 and 1 may capture on another channel's clock or match.
// (RL18) Buffered output compare copies buffer into general register on match.
// (RL19) Buffered capture moves the old register value into the buffer.
// (RL20) Channels 1 and 2 join into one 32-bit counter in cascade.
// (RL21) PWM modes give 0% to 100% duty with levels from pin control.
// (RL22) Phase mode counts channels 1 and 2 up or down from quadrature pins.
// (RL23) Clearing a run bit stops counting but keeps the pin level.
// (RL24) Channel 0: third register buffers the first, fourth the second.
// (RL25) Cascaded upper counter steps up on lower overflow, down on underflow.
// (RL26) Channels 1 and 2 count down only in phase or cascade operation.
// (RL27) Capture and clock pins pass two flip-flops before edge detection.
// (RL28) A bus counter write wins over count, clear or preset that cycle.
package mtc_pkg;
	// ============================================================
	// register map, offsets within a channel, channel in addr[5:4]
	localparam logic [3:0] OFS_CTL = 4'h0; // control hi, mode lo
	localparam logic [3:0] OFS_IO = 4'h2; // pins A,B hi, pins C,D lo
	localparam logic [3:0] OFS_IRQ = 4'h4; // irq enable hi, flags lo
	localparam logic [3:0] OFS_CNT = 4'h6;
	localparam logic [3:0] OFS_GRA = 4'h8; // general regs A..D at 8..E
	localparam logic [7:0] OFS_GLOBAL = 8'h30; // run hi, sync lo
	// ============================================================
	// field positions
	localparam int unsigned MODE_BUFA = 0; // BUFB is next bit
	localparam int unsigned MODE_PWM1 = 2;
	localparam int unsigned MODE_PWM2 = 3;
	localparam int unsigned MODE_PHASE = 4;
	localparam int unsigned FLG_OVF = 4;
	localparam int unsigned FLG_UNF = 5;
	localparam int unsigned IO_CAP = 3; // 1 = input capture
	localparam int unsigned IO_INIT = 2; // initial level, or alt source
	// ============================================================
	// codes
	localparam logic [2:0] PSC_DIV1 = 3'h0;
	localparam logic [2:0] PSC_DIV4 = 3'h1;
	localparam logic [2:0] PSC_DIV16 = 3'h2;
	localparam logic [2:0] PSC_DIV64 = 3'h3;
	localparam logic [2:0] PSC_EXT0 = 3'h4;
	localparam logic [2:0] PSC_EXT1 = 3'h5;
	localparam logic [2:0] PSC_CASCADE = 3'h7;
	localparam logic [2:0] CLR_NONE = 3'h0;
	localparam logic [2:0] CLR_GRA = 3'h1; // 1..4 clear on A..D
	localparam logic [2:0] CLR_GRD = 3'h4;
	localparam logic [2:0] CLR_SYNC = 3'h5;
	localparam logic [1:0] ACT_LOW = 2'h1;
	localparam logic [1:0] ACT_HIGH = 2'h2;
	localparam logic [1:0] ACT_TOG = 2'h3;
	localparam logic [1:0] EDG_FALL = 2'h2; // other codes: rising
	localparam logic [1:0] EDG_BOTH = 2'h3;
	// ============================================================
	// reset values and widths
	localparam logic [15:0] GR_RST = 16'hFFFF;
	localparam logic [15:0] CNT_RST = 16'h0000;
	localparam logic [15:0] CNT_MAX = 16'hFFFF;
	localparam logic [7:0] IEN_MASK = 8'h3F;
	localparam int unsigned PIN_W = 10; // 8 capture pins, 2 clock pins
	// ============================================================
	// carriers
	typedef struct packed {
		logic wr;
		logic rd;
		logic [1:0] be; // be[1] upper byte
		logic [7:0] addr;
		logic [15:0] wdata;
	} mtc_bus_req_t;
	typedef struct packed {
		logic [PIN_W-1:0] level;
		logic [PIN_W-1:0] rise;
		logic [PIN_W-1:0] fall;
	} mtc_edges_t;
endpackage

/* File: mtc_top.sv */
/*
 mtc_top: three-channel 16-bit timer with compare, capture, buffer,
 cascade, pwm and phase counting, plus its 16-bit register port.
 Assumes the bus master holds each request one cycle; read data
 appears on the next cycle.
*/
`timescale 1ns/1ps
module mtc_top (
	// clock and reset
	input wire logic clock_in,
	input wire logic reset_n_in,
	input wire logic standby_in,
	// register port
	input wire mtc_pkg::mtc_bus_req_t bus_req_in,
	output logic [15:0] bus_rdata_out,
	// capture/compare pins
	input wire logic [7:0] capture_compare_pin_in,
	output logic [7:0] capture_compare_pin_out,
	output logic [7:0] capture_compare_pin_oe_n_out,
	// external count clocks
	input wire logic [1:0] external_count_clock_pin_in,
	// interrupt requests, one per channel
	output logic [2:0] irq_out
);
	typedef struct packed {
		logic [2:0] run; // counter_start_reg
		logic [2:0] sync; // timer_sync_select
		logic [2:0][7:0] ctl; // clear[7:5] edge[4:3] prescale[2:0]
		logic [2:0][7:0] mode;
		logic [2:0][3:0][3:0] io;
		logic [2:0][7:0] ien;
		logic [2:0][7:0] flags;
		logic [2:0][7:0] seen; // flags read as one
		logic [2:0][15:0] cnt;
		logic [2:0][3:0][15:0] gr;
		logic [7:0] pin;
		logic [5:0] presc;
		logic [15:0] rdata;
	} mtc_state_t;

	localparam mtc_state_t ST_RST = '{gr: {12{mtc_pkg::GR_RST}}, default: '0};

	mtc_state_t st, next_st;
	mtc_pkg::mtc_edges_t ed;

	// ============================================================
	// helpers
	function automatic logic gr_ok(input int c, input int g);
		return c == 0 || g < 2;
	endfunction

	function automatic logic [2:0] pin_of(input int c, input int g);
		return 3'(c == 0 ? g : 2 * c + g + 2);
	endfunction

	function automatic logic buf_slot(input logic [7:0] m, input int c, input int g);
		return c == 0 && g >= 2 && m[mtc_pkg::MODE_BUFA + g - 2];
	endfunction

	function automatic logic edge_hit(input logic [1:0] sel, input logic r, input logic f);
		if (sel == mtc_pkg::EDG_FALL) begin
			return f;
		end else if (sel == mtc_pkg::EDG_BOTH) begin
			return r | f;
		end
		return r;
	endfunction

	function automatic logic [7:0] byte_wr(input logic [7:0] old, input logic en,
		input logic [7:0] d);
		return en ? d : old;
	endfunction

	// ============================================================
	// pin conditioning
	mtc_pin_sync u_sync (
		.clock_in(clock_in),
		.reset_n_in(reset_n_in),
		.raw_in({external_count_clock_pin_in, capture_compare_pin_in}),
		.edges_out(ed)
	);

	// ============================================================
	// next state
	always_comb begin
		logic [2:0] tk, up, dn, ovf, unf, own, clr;
		logic [2:0][3:0] mt, cp;
		logic a_chg, b_chg, qx, anysc, src, chw, glw, chr, glr;
		logic [1:0] ch;
		logic [3:0] off, nio;
		logic [2:0] cc, tp;
		logic [7:0] cm;
		logic [15:0] rw;
		tk = '0;
		up = '0;
		dn = '0;
		ovf = '0;
		unf = '0;
		own = '0;
		clr = '0;
		mt = '0;
		cp = '0;
		src = 1'b0;
		nio = '0;
		cc = '0;
		tp = '0;
		cm = '0;
		rw = '0;
		next_st = st;
		next_st.presc = st.presc + 6'h01;
		a_chg = ed.rise[8] | ed.fall[8];
		b_chg = ed.rise[9] | ed.fall[9];
		qx = ed.level[8] ^ ed.level[9];
		ch = bus_req_in.addr[5:4];
		off = {bus_req_in.addr[3:1], 1'b0};
		chw = bus_req_in.wr && bus_req_in.addr[7:6] == 2'h0 && ch != 2'h3;
		chr = bus_req_in.rd && bus_req_in.addr[7:6] == 2'h0 && ch != 2'h3;
		glw = bus_req_in.wr && bus_req_in.addr[7:1] == mtc_pkg::OFS_GLOBAL[7:1];
		glr = bus_req_in.rd && bus_req_in.addr[7:1] == mtc_pkg::OFS_GLOBAL[7:1];

		// count events, lower channel first for cascade
		for (int c = 2; c >= 0; c--) begin
			unique case (st.ctl[c][2:0])
				mtc_pkg::PSC_DIV1: tk[c] = 1'b1;
				mtc_pkg::PSC_DIV4: tk[c] = &st.presc[1:0];
				mtc_pkg::PSC_DIV16: tk[c] = &st.presc[3:0];
				mtc_pkg::PSC_DIV64: tk[c] = &st.presc;
				mtc_pkg::PSC_EXT0: tk[c] = edge_hit(st.ctl[c][4:3], ed.rise[8], ed.fall[8]);
				mtc_pkg::PSC_EXT1: tk[c] = edge_hit(st.ctl[c][4:3], ed.rise[9], ed.fall[9]);
				default: tk[c] = c != 1; // cascade has no own clock
			endcase
			if (c != 0 && st.mode[c][mtc_pkg::MODE_PHASE]) begin
				up[c] = st.run[c] & (a_chg ^ b_chg) & (a_chg ? qx : ~qx); // RL22
				dn[c] = st.run[c] & (a_chg ^ b_chg) & (a_chg ? ~qx : qx); // RL22
			end else if (c == 1 && st.ctl[1][2:0] == mtc_pkg::PSC_CASCADE) begin
				up[c] = st.run[1] & ovf[2]; // RL20
				dn[c] = st.run[1] & unf[2]; // RL25
			end else begin
				up[c] = st.run[c] & tk[c]; // RL8 RL26
			end
			ovf[c] = up[c] && st.cnt[c] == mtc_pkg::CNT_MAX;
			unf[c] = dn[c] && st.cnt[c] == mtc_pkg::CNT_RST;
			for (int g = 0; g < 4; g++) begin
				mt[c][g] = gr_ok(c, g) && !buf_slot(st.mode[0], c, g)
					&& !st.io[c][g][mtc_pkg::IO_CAP] && (up[c] || dn[c])
					&& st.cnt[c] == st.gr[c][g];
			end
		end

		// captures and clear sources
		for (int c = 0; c < 3; c++) begin
			for (int g = 0; g < 4; g++) begin
				if (st.io[c][g][mtc_pkg::IO_INIT] && c < 2) begin
					src = c == 0 ? tk[1] : mt[0][0]; // RL17
				end else begin
					src = edge_hit(st.io[c][g][1:0], ed.rise[pin_of(c, g)],
						ed.fall[pin_of(c, g)]); // RL16
				end
				cp[c][g] = gr_ok(c, g) && !buf_slot(st.mode[0], c, g)
					&& st.io[c][g][mtc_pkg::IO_CAP] && src;
			end
			cc = st.ctl[c][7:5];
			own[c] = cc >= mtc_pkg::CLR_GRA && cc <= mtc_pkg::CLR_GRD
				&& (mt[c][2'(cc - mtc_pkg::CLR_GRA)] || cp[c][2'(cc - mtc_pkg::CLR_GRA)]);
		end
		anysc = |(st.sync & own);
		for (int c = 0; c < 3; c++) begin
			clr[c] = own[c] || (st.sync[c] && st.ctl[c][7:5] == mtc_pkg::CLR_SYNC
				&& anysc); // RL5
		end

		// register writes other than the counters
		if (glw) begin
			next_st.run = bus_req_in.be[1] ? bus_req_in.wdata[10:8] : st.run;
			next_st.sync = bus_req_in.be[0] ? bus_req_in.wdata[2:0] : st.sync; // RL2
		end
		if (chw) begin
			if (off == mtc_pkg::OFS_CTL) begin // RL7
				next_st.ctl[ch] = byte_wr(st.ctl[ch], bus_req_in.be[1], bus_req_in.wdata[15:8]);
				next_st.mode[ch] = byte_wr(st.mode[ch], bus_req_in.be[0], bus_req_in.wdata[7:0]);
			end
			if (off == mtc_pkg::OFS_IO) begin
				for (int g = 0; g < 4; g++) begin
					nio = bus_req_in.wdata[(g < 2 ? 8 : 0) + 4 * (g % 2) +: 4];
					if (bus_req_in.be[g < 2 ? 1 : 0] && gr_ok(ch, g)) begin
						next_st.io[ch][g] = nio;
						if (!st.run[ch] && !nio[mtc_pkg::IO_CAP]) begin
							next_st.pin[pin_of(ch, g)] = nio[mtc_pkg::IO_INIT]; // RL14
						end
					end
				end
			end
			if (off == mtc_pkg::OFS_IRQ) begin
				next_st.ien[ch] = byte_wr(st.ien[ch], bus_req_in.be[1],
					bus_req_in.wdata[15:8] & mtc_pkg::IEN_MASK);
				cm = bus_req_in.be[0] ? ~bus_req_in.wdata[7:0] & st.seen[ch] : 8'h00;
				next_st.flags[ch] = st.flags[ch] & ~cm;
				next_st.seen[ch] = st.seen[ch] & ~cm;
			end
			if (off[3] && bus_req_in.be == 2'h3 && gr_ok(ch, off[2:1])) begin
				next_st.gr[ch][off[2:1]] = bus_req_in.wdata; // RL6
			end
		end

		// timer events, set wins over a same-cycle flag clear
		for (int c = 0; c < 3; c++) begin
			if (clr[c]) begin
				next_st.cnt[c] = mtc_pkg::CNT_RST; // RL11
			end else if (up[c]) begin
				next_st.cnt[c] = st.cnt[c] + 16'h0001; // RL9
			end else if (dn[c]) begin
				next_st.cnt[c] = st.cnt[c] - 16'h0001; // RL26
			end
			next_st.flags[c][mtc_pkg::FLG_OVF] = next_st.flags[c][mtc_pkg::FLG_OVF] | ovf[c];
			next_st.flags[c][mtc_pkg::FLG_UNF] = next_st.flags[c][mtc_pkg::FLG_UNF] | unf[c];
			next_st.flags[c][3:0] = next_st.flags[c][3:0] | mt[c] | cp[c]; // RL11 RL12
			for (int g = 0; g < 4; g++) begin
				if (cp[c][g]) begin
					next_st.gr[c][g] = st.cnt[c]; // RL16
					if (g < 2 && buf_slot(st.mode[0], c, g + 2)) begin
						next_st.gr[0][2'(g + 2)] = st.gr[0][g]; // RL19 RL24
					end
				end
				// only A and B have buffers, so C and D never reach past the array
				if (g < 2 && mt[c][g] && buf_slot(st.mode[0], c, g + 2)) begin
					next_st.gr[0][g] = st.gr[0][2'(g + 2)]; // RL18 RL24
				end
				tp = st.mode[c][mtc_pkg::MODE_PWM1] && g % 2 == 1 ? pin_of(c, g - 1)
					: pin_of(c, g);
				if (mt[c][g] && !(st.mode[c][mtc_pkg::MODE_PWM1]
					&& st.gr[c][g] == st.gr[c][g ^ 1])) begin
					unique case (st.io[c][g][1:0])
						mtc_pkg::ACT_LOW: next_st.pin[tp] = 1'b0; // RL13 RL15
						mtc_pkg::ACT_HIGH: next_st.pin[tp] = 1'b1; // RL13 RL15
						mtc_pkg::ACT_TOG: next_st.pin[tp] = ~st.pin[tp]; // RL13
						default: next_st.pin[tp] = next_st.pin[tp];
					endcase
				end
				if (st.mode[c][mtc_pkg::MODE_PWM2] && clr[c] && gr_ok(c, g)
					&& !st.io[c][g][mtc_pkg::IO_CAP]) begin
					next_st.pin[pin_of(c, g)] = st.io[c][g][mtc_pkg::IO_INIT]; // RL21
				end
			end
		end

		// counter writes last, preset to all synced channels
		if (chw && off == mtc_pkg::OFS_CNT && bus_req_in.be == 2'h3) begin // RL6
			for (int k = 0; k < 3; k++) begin
				if (k == ch || (st.sync[ch] && st.sync[k])) begin
					next_st.cnt[k] = bus_req_in.wdata; // RL3 RL28
				end
			end
		end

		// read data, registered
		if (glr) begin
			rw = {5'h00, st.run, 5'h00, st.sync}; // RL2
		end else if (chr && off[3]) begin
			rw = gr_ok(ch, off[2:1]) ? st.gr[ch][off[2:1]] : 16'h0000;
		end else if (chr) begin
			unique case (off)
				mtc_pkg::OFS_CTL: rw = {st.ctl[ch], st.mode[ch]};
				mtc_pkg::OFS_IO: rw = {st.io[ch][1], st.io[ch][0], st.io[ch][3], st.io[ch][2]};
				mtc_pkg::OFS_IRQ: rw = {st.ien[ch], st.flags[ch]};
				mtc_pkg::OFS_CNT: rw = st.cnt[ch];
				default: rw = 16'h0000;
			endcase
			if (off == mtc_pkg::OFS_IRQ && bus_req_in.be[0]) begin
				next_st.seen[ch] = st.flags[ch];
			end
		end
		if (bus_req_in.rd) begin
			next_st.rdata = rw;
		end

		// standby re-initialises every timer register; the pin synchroniser keeps its state
		if (standby_in) begin
			next_st = ST_RST; // RL1
		end
	end

	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			st <= ST_RST; // RL1 RL9
		end else begin
			st <= next_st; // RL23
		end
	end

	// ============================================================
	// outputs
	function automatic logic [7:0] drive_n(input logic [2:0][3:0][3:0] io);
		drive_n = 8'hFF;
		for (int c = 0; c < 3; c++) begin
			for (int g = 0; g < 4; g++) begin
				if (gr_ok(c, g) && !io[c][g][mtc_pkg::IO_CAP] && io[c][g] != 4'h0) begin
					drive_n[pin_of(c, g)] = 1'b0;
				end
			end
		end
	endfunction

	function automatic logic [2:0] irq_of(input logic [2:0][7:0] f, input logic [2:0][7:0] e);
		for (int c = 0; c < 3; c++) begin
			irq_of[c] = |(f[c] & e[c]); // RL10 RL12
		end
	endfunction

	assign bus_rdata_out = st.rdata;
	assign capture_compare_pin_out = st.pin;
	assign capture_compare_pin_oe_n_out = drive_n(st.io);
	assign irq_out = irq_of(st.flags, st.ien);

	// ============================================================
	// assertions
	logic quiet;
	assign quiet = !bus_req_in.wr && !standby_in;
	default clocking @(posedge clock_in); endclocking
	default disable iff (!reset_n_in);

	a_sync_standby_clear: assert property (standby_in |=> st.sync == 3'h0) // RL1
		else $error("sync select not cleared by standby");
	a_sync_read_zero: assert property (bus_req_in.rd && bus_req_in.addr == mtc_pkg::OFS_GLOBAL // RL2
		&& !standby_in |=> bus_rdata_out[7:3] == 5'h00 && bus_rdata_out[2:0] == $past(st.sync))
		else $error("sync select read wrong");
	a_sync_preset_all: assert property (bus_req_in.wr && bus_req_in.be == 2'h3 // RL3
		&& bus_req_in.addr == {4'h0, mtc_pkg::OFS_CNT} && st.sync[0] && st.sync[2]
		&& !standby_in |=> st.cnt[2] == $past(bus_req_in.wdata))
		else $error("synced counter not preset");
	a_byte_gr_ignored: assert property (bus_req_in.wr && bus_req_in.be != 2'h3 // RL6
		&& bus_req_in.addr == {4'h0, mtc_pkg::OFS_GRA} && !st.run[0]
		&& !st.io[0][0][mtc_pkg::IO_CAP] && !standby_in |=> $stable(st.gr[0][0]))
		else $error("byte write changed a general register");
	a_stopped_hold: assert property (!st.run[0] && quiet // RL8
		&& st.ctl[0][7:5] == mtc_pkg::CLR_NONE |=> $stable(st.cnt[0]))
		else $error("stopped counter moved");
	a_wrap_flag: assert property (st.run[2] && st.ctl[2] == 8'h00 && st.mode[2] == 8'h00 // RL9
		&& quiet && st.cnt[2] == mtc_pkg::CNT_MAX |=> st.cnt[2] == 16'h0000
		&& st.flags[2][mtc_pkg::FLG_OVF])
		else $error("wrap did not clear counter and set overflow");
	a_overflow_irq: assert property (st.run[2] && st.ctl[2] == 8'h00 && st.mode[2] == 8'h00 // RL10
		&& quiet && st.cnt[2] == mtc_pkg::CNT_MAX && st.ien[2][mtc_pkg::FLG_OVF] |=> irq_out[2])
		else $error("overflow did not request interrupt");
	a_period_clear: assert property (st.run[0] && quiet && !st.io[0][0][mtc_pkg::IO_CAP] // RL11
		&& st.ctl[0] == {mtc_pkg::CLR_GRA, 5'h00} && st.cnt[0] == st.gr[0][0]
		|=> st.cnt[0] == 16'h0000 && st.flags[0][0])
		else $error("match did not clear counter");
	a_toggle_pin: assert property (st.run[0] && quiet && st.ctl[0][2:0] == mtc_pkg::PSC_DIV1 // RL13
		&& st.mode[0] == 8'h00 && !st.io[0][0][mtc_pkg::IO_CAP]
		&& st.io[0][0][1:0] == mtc_pkg::ACT_TOG
		&& st.cnt[0] == st.gr[0][0] |=> capture_compare_pin_out[0] != $past(st.pin[0]))
		else $error("toggle match did not flip the pin");
endmodule // mtc_top

/* File: multichannel_timer_capture_compare_tb.sv */
/*
 multichannel_timer_capture_compare_tb: self-checking bench for mtc_top.
 Assumes the bus master model drives the register port.
*/
`timescale 1ns/1ps
module multichannel_timer_capture_compare_tb;
	// ============================================================
	// signals
	logic clock_in = 1'b0;
	logic reset_n_in = 1'b0;
	logic standby_in = 1'b0;
	logic [7:0] cap_pin = 8'h00;
	logic [1:0] ext_clk = 2'h0;
	mtc_pkg::mtc_bus_req_t req;
	logic [15:0] rdata;
	logic [7:0] pin_out;
	logic [7:0] oe_n;
	logic [2:0] irq;
	int err_count = 0;
	int num_checks = 0;
	// 40 MHz clock
	always #12.5 clock_in = ~clock_in;
	// ============================================================
	// instances
	mtc_top dut_u (
		.clock_in(clock_in), .reset_n_in(reset_n_in), .standby_in(standby_in),
		.bus_req_in(req), .bus_rdata_out(rdata),
		.capture_compare_pin_in(cap_pin), .capture_compare_pin_out(pin_out),
		.capture_compare_pin_oe_n_out(oe_n),
		.external_count_clock_pin_in(ext_clk), .irq_out(irq)
	);
	mtc_bus_master bfm_u (.clock_in(clock_in), .bus_req_out(req), .bus_rdata_in(rdata));
	// ============================================================
	// shared tasks
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [1:0] be, input logic [15:0] d);
		bfm_u.bus_write(a, be, d);
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [15:0] exp);
		logic [15:0] v;
		bfm_u.bus_read(a, v);
		check(v, exp);
	endtask
	// bounded wait for one interrupt line
	task automatic wait_irq(input int idx, input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge clock_in);
			#1;
			if (irq[idx] === 1'b1) break;
		end
	endtask
	// ============================================================
	// scenarios
	task automatic t_reset;
		check({8'h00, oe_n}, 16'h00FF);
		rdchk(8'h30, 16'h0000);
		rdchk(8'h06, 16'h0000);
		wr(8'h08, 2'h2, 16'h1200);
		rdchk(8'h08, 16'hFFFF);
		wr(8'h30, 2'h1, 16'h00FF);
		rdchk(8'h30, 16'h0007);
		wr(8'h30, 2'h1, 16'h0000);
	endtask
	task automatic t_sync;
		wr(8'h30, 2'h1, 16'h0005);
		wr(8'h06, 2'h3, 16'h1234);
		rdchk(8'h26, 16'h1234);
		rdchk(8'h16, 16'h0000);
		wr(8'h26, 2'h1, 16'h00FF);
		rdchk(8'h26, 16'h1234);
		wr(8'h30, 2'h1, 16'h0000);
	endtask
	task automatic t_width;
		wr(8'h10, 2'h3, 16'hA004);
		rdchk(8'h10, 16'hA004);
		wr(8'h10, 2'h2, 16'h4000);
		rdchk(8'h10, 16'h4004);
		wr(8'h10, 2'h3, 16'h0000);
	endtask
	task automatic t_overflow;
		logic [15:0] v1;
		logic [15:0] v2;
		wr(8'h24, 2'h2, 16'h1000);
		wr(8'h26, 2'h3, 16'hFFFE);
		rdchk(8'h26, 16'hFFFE);
		wr(8'h30, 2'h2, 16'h0400);
		wait_irq(2, 10);
		check({15'h0, irq[2]}, 16'h0001);
		wr(8'h30, 2'h2, 16'h0000);
		rdchk(8'h24, 16'h1013);
		bfm_u.bus_read(8'h26, v1);
		bfm_u.bus_read(8'h26, v2);
		check(v2, v1);
		check({15'h0, v1 < 16'h0020}, 16'h0001);
		wr(8'h24, 2'h1, 16'h0000);
		#1;
		check({15'h0, irq[2]}, 16'h0000);
	endtask
	task automatic t_periodic;
		logic [15:0] v;
		wr(8'h06, 2'h3, 16'h0000);
		wr(8'h00, 2'h2, 16'h2000);
		wr(8'h08, 2'h3, 16'h0005);
		wr(8'h02, 2'h2, 16'h0700);
		#1;
		check({15'h0, pin_out[0]}, 16'h0001);
		check({15'h0, oe_n[0]}, 16'h0000);
		wr(8'h04, 2'h2, 16'h0100);
		wr(8'h30, 2'h2, 16'h0100);
		wait_irq(0, 20);
		check({15'h0, irq[0]}, 16'h0001);
		check({15'h0, pin_out[0]}, 16'h0000);
		wr(8'h30, 2'h2, 16'h0000);
		bfm_u.bus_read(8'h06, v);
		check({15'h0, v <= 16'h0005}, 16'h0001);
		repeat (4) @(posedge clock_in);
		check({15'h0, pin_out[0]}, 16'h0000);
		rdchk(8'h04, 16'h0101);
		wr(8'h04, 2'h1, 16'h0000);
	endtask
	task automatic t_capture;
		wr(8'h12, 2'h2, 16'h0900);
		wr(8'h16, 2'h3, 16'h0042);
		@(posedge clock_in);
		cap_pin[4] <= 1'b1;
		repeat (5) @(posedge clock_in);
		rdchk(8'h18, 16'h0042);
		rdchk(8'h14, 16'h0001);
	endtask
	// quadrature on channel 1: a-leading steps up four, b-leading back down
	task automatic t_phase;
		logic [1:0] seq [8];
		seq = '{2'h1, 2'h3, 2'h2, 2'h0, 2'h2, 2'h3, 2'h1, 2'h0};
		wr(8'h16, 2'h3, 16'h0100);
		wr(8'h10, 2'h1, 16'h0010);
		wr(8'h30, 2'h2, 16'h0200);
		for (int i = 0; i < 8; i++) begin
			@(posedge clock_in);
			ext_clk <= seq[i];
			repeat (3) @(posedge clock_in);
			if (i == 3) begin
				rdchk(8'h16, 16'h0104);
			end
		end
		rdchk(8'h16, 16'h0100);
		wr(8'h30, 2'h2, 16'h0000);
		wr(8'h10, 2'h1, 16'h0000);
	endtask
	task automatic t_standby;
		wr(8'h30, 2'h1, 16'h0005);
		@(posedge clock_in);
		standby_in <= 1'b1;
		@(posedge clock_in);
		standby_in <= 1'b0;
		rdchk(8'h30, 16'h0000);
		rdchk(8'h08, 16'hFFFF);
	endtask
	// ============================================================
	// verdict and end of run
	task automatic close_out;
		if (err_count == 0 && num_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// watchdog cuts a hang short
	initial begin
		#100000;
		err_count++;
		close_out();
	end
	// main sequence
	initial begin
		repeat (4) @(posedge clock_in);
		reset_n_in <= 1'b1;
		t_reset();
		t_sync();
		t_width();
		t_overflow();
		t_periodic();
		t_capture();
		t_phase();
		t_standby();
		close_out();
	end
endmodule // multichannel_timer_capture_compare_tb
